// ---- rtl/interrupt_flag_priority_unit.sv ----
// interrupt flag storage and priority resolution for the cpu core
// assumes one clock, APB register access, cpu pulses ack and return
//
// Notes on behaviour
// - radio request is two flag bits 1 and 0; either one pending requests service
// - a radio request sets both radio flag bits together
// - bits 7 to 2 of the radio flag register are unused and zero
// - timer 1-4 flags in bits 1-4 set on event, cleared on vectoring
// - timer/dma register: sleep timer bit 7, port 0 bit 5, dma bit 0
// - port/serial register: watchdog 4, port1 3, tx1 2, tx0 1, port2 0
// - all flags reset to zero; one means pending
// - sources form six groups set by two priority registers
// - each group has one of four levels shared by its sources
// - a running service is not preempted by equal or lower level
// - simultaneous equal-level requests are chosen by fixed polling order
// - high priority register holds upper level bits 5-0, bits 7-6 zero
// - high and low bits form level 0 lowest to 3 highest
// - fixed assignment of the eighteen sources to the six groups
// - polling order 0,16,8,1,9,2,10,3,11,4,12,5,13,6,7,14,15,17
// - flags set on their condition regardless of enables
`timescale 1ns/1ps
module interrupt_flag_priority_unit import irq_unit_pkg::*; (
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_W-1:0]      paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire periph_events_s         periph_events,
  input  wire other_flags_s           other_flags,
  input  wire logic [NUM_SOURCES-1:0] source_enable,
  output cpu_request_s                cpu_request,
  input  wire logic                   cpu_vector_ack,
  input  wire logic                   cpu_return,
  output logic                        event_irq
);

  // ***************************************************
  // declarations
  // ***************************************************
  logic [7:0]             radio_flags_reg;
  logic [7:0]             timer_dma_flags_reg;
  logic [7:0]             port_ser_flags_reg;
  logic [7:0]             prio_high_reg;
  logic [7:0]             prio_low_reg;

  logic [EVT_W-1:0]       event_status_reg;
  logic [EVT_W-1:0]       event_mask_reg;
  logic [NUM_LEVELS-1:0]  in_service_reg;
  logic [NUM_LEVELS-1:0]  in_service_next;

  logic [31:0]            prdata_reg;

  logic                   req_valid_reg;
  logic [4:0]             req_number_reg;
  logic [1:0]             req_level_reg;

  logic [7:0]             word_index;
  logic                   addr_hit;
  logic                   setup_phase;
  logic                   write_commit;
  logic [31:0]            read_value;

  logic                   wr_radio;
  logic                   wr_timer_dma;
  logic                   wr_port_ser;
  logic                   wr_event_status;

  logic [7:0]             radio_set;
  logic [7:0]             timer_dma_set;
  logic [7:0]             port_ser_set;
  logic [7:0]             timer_dma_clear;

  logic [NUM_SOURCES-1:0] pending;
  logic                   win_valid;
  logic [4:0]             win_number;
  logic [1:0]             win_level;

  logic                   take_vector;
  logic                   bad_return;
  logic [EVT_W-1:0]       event_set;

  // ***************************************************
  // apb decode
  // ***************************************************
  assign word_index   = paddr[ADDR_W-1:2];
  assign setup_phase  = psel && !penable;

  // zero wait states: every access completes in its first access cycle
  assign pready       = 1'b1;
  assign write_commit = psel && penable && pwrite && addr_hit;
  assign pslverr      = psel && penable && !addr_hit;
  assign prdata       = prdata_reg;

  always_comb begin
    addr_hit   = 1'b1;
    read_value = 32'h0000_0000;

    if (word_index == IDX_RADIO_FLAGS) begin
      read_value[7:0] = radio_flags_reg;
    end else if (word_index == IDX_PRIO_LOW) begin
      read_value[7:0] = prio_low_reg;
    end else if (word_index == IDX_PRIO_HIGH) begin
      read_value[7:0] = prio_high_reg;
    end else if (word_index == IDX_TIMER_DMA_FLAGS) begin
      read_value[7:0] = timer_dma_flags_reg;
    end else if (word_index == IDX_PORT_SER_FLAGS) begin
      read_value[7:0] = port_ser_flags_reg;
    end else if (word_index == IDX_EVENT_STATUS) begin
      read_value[EVT_W-1:0] = event_status_reg;
    end else if (word_index == IDX_EVENT_MASK) begin
      read_value[EVT_W-1:0] = event_mask_reg;
    end else if (word_index == IDX_IN_SERVICE) begin
      read_value[NUM_LEVELS-1:0] = in_service_reg;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // read data captured in the setup cycle, stable through the access cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata_reg <= read_value;
    end
  end

  assign wr_radio        = write_commit && word_index == IDX_RADIO_FLAGS;
  assign wr_timer_dma    = write_commit && word_index == IDX_TIMER_DMA_FLAGS;
  assign wr_port_ser     = write_commit && word_index == IDX_PORT_SER_FLAGS;
  assign wr_event_status = write_commit && word_index == IDX_EVENT_STATUS;

  // ***************************************************
  // priority registers
  // ***************************************************
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prio_high_reg <= PRIO_RESET;
      prio_low_reg  <= PRIO_RESET;
    end else if (write_commit) begin
      if (word_index == IDX_PRIO_HIGH) begin
        prio_high_reg <= pwdata[7:0] & PRIO_USED;
      end
      if (word_index == IDX_PRIO_LOW) begin
        prio_low_reg <= pwdata[7:0] & PRIO_USED;
      end
    end
  end

  // ***************************************************
  // flag registers
  // ***************************************************
  // sets ignore source_enable: flags record the condition regardless
  always_comb begin
    radio_set     = 8'h00;
    timer_dma_set = 8'h00;
    port_ser_set  = 8'h00;

    radio_set[RADIO_HI_BIT]        = periph_events.radio;
    radio_set[RADIO_LO_BIT]        = periph_events.radio;
    timer_dma_set[SLEEP_BIT]       = periph_events.sleep_timer;
    timer_dma_set[PORT0_BIT]       = periph_events.port0;
    timer_dma_set[DMA_BIT]         = periph_events.dma_done;
    timer_dma_set[TIMER1_BIT +: 4] = periph_events.timer;
    port_ser_set[WATCHDOG_BIT]     = periph_events.watchdog;
    port_ser_set[PORT1_BIT]        = periph_events.port1;
    port_ser_set[SER1_TX_BIT]      = periph_events.serial1_tx;
    port_ser_set[SER0_TX_BIT]      = periph_events.serial0_tx;
    port_ser_set[PORT2_BIT]        = periph_events.port2;
  end

  // only the timer flags are cleared by vectoring; the rest wait for software
  always_comb begin
    timer_dma_clear = 8'h00;
    if (take_vector && req_number_reg >= SRC_TIMER1 &&
        req_number_reg <= SRC_TIMER4) begin
      timer_dma_clear[TIMER1_BIT + 32'(req_number_reg - SRC_TIMER1)] = 1'b1;
    end
  end

  // unused bits are masked inside and never hold a one
  flag_register #(
    .WIDTH     (8),
    .USED_MASK (RADIO_USED)
  ) u_radio_flags (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .write_en   (wr_radio),
    .write_data (pwdata[7:0]),
    .set_bits   (radio_set),
    .clear_bits (8'h00),
    .flags_reg  (radio_flags_reg)
  );

  flag_register #(
    .WIDTH     (8),
    .USED_MASK (TIMER_DMA_USED)
  ) u_timer_dma_flags (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .write_en   (wr_timer_dma),
    .write_data (pwdata[7:0]),
    .set_bits   (timer_dma_set),
    .clear_bits (timer_dma_clear),
    .flags_reg  (timer_dma_flags_reg)
  );

  flag_register #(
    .WIDTH     (8),
    .USED_MASK (PORT_SER_USED)
  ) u_port_ser_flags (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .write_en   (wr_port_ser),
    .write_data (pwdata[7:0]),
    .set_bits   (port_ser_set),
    .clear_bits (8'h00),
    .flags_reg  (port_ser_flags_reg)
  );

  // ***************************************************
  // pending vector by interrupt number
  // ***************************************************
  always_comb begin
    pending     = '0;
    // numbers 0 to 4: flags held by their own peripherals
    pending[0]  = other_flags.rf_error;
    pending[1]  = other_flags.adc;
    pending[2]  = other_flags.serial0_rx;
    pending[3]  = other_flags.serial1_rx;
    pending[4]  = other_flags.aes;

    // numbers 5 to 17: flags stored in this block
    pending[5]  = timer_dma_flags_reg[SLEEP_BIT];
    pending[6]  = port_ser_flags_reg[PORT2_BIT];
    pending[7]  = port_ser_flags_reg[SER0_TX_BIT];
    pending[8]  = timer_dma_flags_reg[DMA_BIT];
    pending[9]  = timer_dma_flags_reg[TIMER1_BIT];
    pending[10] = timer_dma_flags_reg[TIMER1_BIT + 1];
    pending[11] = timer_dma_flags_reg[TIMER1_BIT + 2];
    pending[12] = timer_dma_flags_reg[TIMER1_BIT + 3];
    pending[13] = timer_dma_flags_reg[PORT0_BIT];
    pending[14] = port_ser_flags_reg[SER1_TX_BIT];
    pending[15] = port_ser_flags_reg[PORT1_BIT];
    pending[16] = radio_flags_reg[RADIO_HI_BIT] | radio_flags_reg[RADIO_LO_BIT];
    pending[17] = port_ser_flags_reg[WATCHDOG_BIT];
  end

  // ***************************************************
  // arbitration and cpu request
  // ***************************************************
  priority_arbiter u_arbiter (
    .candidates     (pending & source_enable),
    .level_bit_high (prio_high_reg[NUM_GROUPS-1:0]),
    .level_bit_low  (prio_low_reg[NUM_GROUPS-1:0]),
    .in_service     (in_service_reg),
    .win_valid      (win_valid),
    .win_number     (win_number),
    .win_level      (win_level)
  );

  // the request is registered so the cpu acks exactly what it saw
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      req_valid_reg  <= 1'b0;
      req_number_reg <= 5'h00;
      req_level_reg  <= 2'h0;
    end else if (take_vector) begin
      // one idle cycle lets the cleared flag and new level settle
      req_valid_reg  <= 1'b0;
    end else begin
      req_valid_reg  <= win_valid;
      req_number_reg <= win_number;
      req_level_reg  <= win_level;
    end
  end

  assign cpu_request.valid  = req_valid_reg;
  assign cpu_request.number = req_number_reg;
  assign cpu_request.level  = req_level_reg;

  // ***************************************************
  // in-service levels
  // ***************************************************
  assign take_vector = cpu_vector_ack && req_valid_reg;
  assign bad_return  = cpu_return && in_service_reg == '0;

  always_comb begin
    in_service_next = in_service_reg;
    // a return ends the highest level in service
    if (cpu_return) begin
      for (int lvl = 0; lvl < NUM_LEVELS; lvl++) begin
        if (in_service_reg[lvl] && (in_service_reg >> (lvl + 1)) == '0) begin
          in_service_next[lvl] = 1'b0;
        end
      end
    end

    // an ack beside a return still opens its level
    if (take_vector) begin
      in_service_next[req_level_reg] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      in_service_reg <= IN_SERVICE_RESET;
    end else begin
      in_service_reg <= in_service_next;
    end
  end

  // ***************************************************
  // sticky events and interrupt output
  // ***************************************************
  always_comb begin
    event_set                 = '0;
    event_set[EVT_DISPATCH]   = take_vector;
    event_set[EVT_NESTED]     = take_vector && in_service_reg != '0;
    event_set[EVT_BAD_RETURN] = bad_return;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      event_status_reg <= EVT_RESET;
    end else if (wr_event_status) begin
      // write one clears; a new event in the same cycle is kept
      event_status_reg <= (event_status_reg & ~pwdata[EVT_W-1:0]) | event_set;
    end else begin
      event_status_reg <= event_status_reg | event_set;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      event_mask_reg <= EVT_RESET;
    end else if (write_commit && word_index == IDX_EVENT_MASK) begin
      event_mask_reg <= pwdata[EVT_W-1:0];
    end
  end

  // level output: high until the event is cleared or masked
  assign event_irq = |(event_status_reg & event_mask_reg);

endmodule // interrupt_flag_priority_unit

// ---- rtl/irq_unit_pkg.sv ----
// constants and carrier types shared by the interrupt flag and priority unit
// assumes an APB slave with 32-bit data, one register per aligned word
package irq_unit_pkg;

  // ***************************************************
  // register map: printed index, byte address is index * 4
  // ***************************************************
  localparam int          ADDR_W              = 10;
  localparam logic [7:0]  IDX_RADIO_FLAGS     = 8'h9B;
  localparam logic [7:0]  IDX_PRIO_LOW        = 8'hA9;
  localparam logic [7:0]  IDX_PRIO_HIGH       = 8'hB9;
  localparam logic [7:0]  IDX_TIMER_DMA_FLAGS = 8'hC0;
  localparam logic [7:0]  IDX_PORT_SER_FLAGS  = 8'hE8;
  localparam logic [7:0]  IDX_EVENT_STATUS    = 8'hF0;
  localparam logic [7:0]  IDX_EVENT_MASK      = 8'hF1;
  localparam logic [7:0]  IDX_IN_SERVICE      = 8'hF2;

  // ***************************************************
  // field positions, used-bit masks and reset values
  // ***************************************************
  localparam int          RADIO_HI_BIT   = 1;
  localparam int          RADIO_LO_BIT   = 0;
  localparam int          SLEEP_BIT      = 7;
  localparam int          PORT0_BIT      = 5;
  localparam int          TIMER1_BIT     = 1;
  localparam int          DMA_BIT        = 0;
  localparam int          WATCHDOG_BIT   = 4;
  localparam int          PORT1_BIT      = 3;
  localparam int          SER1_TX_BIT    = 2;
  localparam int          SER0_TX_BIT    = 1;
  localparam int          PORT2_BIT      = 0;
  localparam logic [7:0]  RADIO_USED     = 8'h03;
  localparam logic [7:0]  TIMER_DMA_USED = 8'hBF;
  localparam logic [7:0]  PORT_SER_USED  = 8'h1F;
  localparam logic [7:0]  PRIO_USED      = 8'h3F;
  localparam logic [7:0]  FLAG_RESET     = 8'h00;
  localparam logic [7:0]  PRIO_RESET     = 8'h00;

  // ***************************************************
  // sources, groups and polling order (by interrupt number)
  // ***************************************************
  localparam int          NUM_SOURCES    = 18;
  localparam int          NUM_GROUPS     = 6;
  localparam int          NUM_LEVELS     = 4;
  localparam logic [4:0]  SRC_TIMER1     = 5'h09;
  localparam logic [4:0]  SRC_TIMER4     = 5'h0C;
  localparam logic [4:0]  POLL_ORDER [NUM_SOURCES] = '{
    5'h00, 5'h10, 5'h08, 5'h01, 5'h09, 5'h02, 5'h0A, 5'h03, 5'h0B,
    5'h04, 5'h0C, 5'h05, 5'h0D, 5'h06, 5'h07, 5'h0E, 5'h0F, 5'h11};
  localparam logic [2:0]  SOURCE_GROUP [NUM_SOURCES] = '{
    3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1, 3'h2, 3'h0,
    3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h3, 3'h4, 3'h0, 3'h5};

  // ***************************************************
  // sticky event status bits
  // ***************************************************
  localparam int          EVT_W          = 3;
  localparam int          EVT_DISPATCH   = 0;
  localparam int          EVT_NESTED     = 1;
  localparam int          EVT_BAD_RETURN = 2;
  localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
  localparam logic [NUM_LEVELS-1:0] IN_SERVICE_RESET = 4'h0;

  typedef struct packed {
    logic       radio;
    logic [3:0] timer;
    logic       dma_done;
    logic       sleep_timer;
    logic       port0;
    logic       port1;
    logic       port2;
    logic       serial0_tx;
    logic       serial1_tx;
    logic       watchdog;
  } periph_events_s;

  typedef struct packed {
    logic rf_error;
    logic adc;
    logic serial0_rx;
    logic serial1_rx;
    logic aes;
  } other_flags_s;

  typedef struct packed {
    logic       valid;
    logic [4:0] number;
    logic [1:0] level;
  } cpu_request_s;

endpackage

// ---- rtl/flag_register.sv ----
// one register of pending flags: software load, hardware set and clear
// assumes set pulses and clear pulses are synchronous to core_clk
`timescale 1ns/1ps
module flag_register import irq_unit_pkg::*; #(
  parameter int               WIDTH     = 8,
  parameter logic [WIDTH-1:0] USED_MASK = '1
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             write_en,
  input  wire logic [WIDTH-1:0] write_data,
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic [WIDTH-1:0] clear_bits,
  output logic      [WIDTH-1:0] flags_reg
);

  logic [WIDTH-1:0] flags_next;

  always_comb begin
    flags_next = write_en ? write_data : flags_reg;
    flags_next = flags_next & ~clear_bits;
    // a set in the same cycle as a clear or write wins
    flags_next = (flags_next | set_bits) & USED_MASK;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      flags_reg <= FLAG_RESET[WIDTH-1:0];
    end else begin
      flags_reg <= flags_next;
    end
  end

endmodule // flag_register

// ---- rtl/priority_arbiter.sv ----
// picks the winning pending source by level, then by polling order
// assumes candidates are already gated by their enables
`timescale 1ns/1ps
module priority_arbiter import irq_unit_pkg::*; (
  input  wire logic [NUM_SOURCES-1:0] candidates,
  input  wire logic [NUM_GROUPS-1:0]  level_bit_high,
  input  wire logic [NUM_GROUPS-1:0]  level_bit_low,
  input  wire logic [NUM_LEVELS-1:0]  in_service,
  output logic                        win_valid,
  output logic      [4:0]             win_number,
  output logic      [1:0]             win_level
);

  logic       found;
  logic       busy;
  logic [1:0] busy_level;
  logic [2:0] grp;
  logic [4:0] num;

  always_comb begin
    found      = 1'b0;
    win_number = 5'h00;
    win_level  = 2'h0;
    busy       = 1'b0;
    busy_level = 2'h0;
    grp        = 3'h0;
    num        = 5'h00;
    for (int lvl = NUM_LEVELS - 1; lvl >= 0; lvl--) begin
      for (int k = 0; k < NUM_SOURCES; k++) begin
        num = POLL_ORDER[k];
        grp = SOURCE_GROUP[num];
        if (!found && candidates[num] &&
            {level_bit_high[grp], level_bit_low[grp]} == 2'(lvl)) begin
          found      = 1'b1;
          win_number = num;
          win_level  = 2'(lvl);
        end
      end
    end
    for (int lvl = 0; lvl < NUM_LEVELS; lvl++) begin
      if (in_service[lvl]) begin
        busy       = 1'b1;
        busy_level = 2'(lvl);
      end
    end
    // equal or lower level never preempts a running service
    win_valid = found && (!busy || win_level > busy_level);
  end

endmodule // priority_arbiter

// ---- verif/irq_unit_checker.sv ----
// assertions on the ports of the interrupt flag and priority unit
// assumes it is bound into the unit; apb reads give data in access cycle
`timescale 1ns/1ps
module irq_unit_checker import irq_unit_pkg::*; (
  input wire logic                   core_clk,
  input wire logic                   reset_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [ADDR_W-1:0]      paddr,
  input wire logic [31:0]            prdata,
  input wire logic [NUM_SOURCES-1:0] source_enable,
  input wire cpu_request_s           cpu_request,
  input wire logic                   cpu_vector_ack
);
  // ***************************************************
  // read access qualifier
  // ***************************************************
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ***************************************************
  // assertions
  // ***************************************************
  radio_unused_a: assert property (rd_acc && paddr == {IDX_RADIO_FLAGS, 2'b00} |-> prdata[31:2] == '0)
    else $error("radio flags show unused bits");
  timer_unused_a: assert property (rd_acc && paddr == {IDX_TIMER_DMA_FLAGS, 2'b00} |->
    (prdata & ~{24'h0, TIMER_DMA_USED}) == '0) else $error("timer flags show unused bits");
  port_unused_a: assert property (rd_acc && paddr == {IDX_PORT_SER_FLAGS, 2'b00} |-> prdata[31:5] == '0)
    else $error("port flags show unused bits");
  prio_unused_a: assert property (rd_acc && paddr == {IDX_PRIO_HIGH, 2'b00} |-> prdata[31:6] == '0)
    else $error("priority high shows unused bits");
  reset_clear_a: assert property (disable iff (1'b0) !reset_n |=> cpu_request == '0 && prdata == '0)
    else $error("outputs not cleared by reset");
  enable_gate_a: assert property ($past(source_enable) == '0 |-> !cpu_request.valid)
    else $error("request without any enable");
  ack_gap_a: assert property (cpu_vector_ack && cpu_request.valid |=> !cpu_request.valid)
    else $error("request not withdrawn after ack");
  number_range_a: assert property (cpu_request.valid |-> cpu_request.number < NUM_SOURCES)
    else $error("request number out of range");
endmodule // irq_unit_checker

bind interrupt_flag_priority_unit irq_unit_checker chk (.core_clk, .reset_n, .psel, .penable, .pwrite,
  .paddr, .prdata, .source_enable, .cpu_request, .cpu_vector_ack);

// ---- verif/cpu_core_model.sv ----
// cpu side: acknowledges a presented request when allowed, forwards returns
// assumes the bench drives accept and ret_cmd after rising edges
`timescale 1ns/1ps
module cpu_core_model import irq_unit_pkg::*; (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         accept,
  input  wire logic         ret_cmd,
  input  wire cpu_request_s cpu_request,
  output logic              cpu_vector_ack,
  output logic              cpu_return
);
  // one ack per presentation; a held accept would otherwise ack the dead cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cpu_vector_ack <= 1'b0;
      cpu_return     <= 1'b0;
    end else begin
      cpu_vector_ack <= accept && cpu_request.valid && !cpu_vector_ack;
      cpu_return     <= ret_cmd;
    end
  end
endmodule // cpu_core_model

// ---- verif/interrupt_flag_priority_unit_tb_top.sv ----
// self-checking bench for the interrupt flag and priority unit
// assumes the checker is bound in and the cpu model sits on the request port
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module interrupt_flag_priority_unit_tb_top import irq_unit_pkg::*; ;
  logic                   core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic                   accept = 0, ret_cmd = 0, pready, pslverr, event_irq, ack, ret;
  logic [ADDR_W-1:0]      paddr = '0;
  logic [31:0]            pwdata = '0, prdata, q;
  logic [NUM_SOURCES-1:0] source_enable = '0;
  periph_events_s         periph_events = '0;
  other_flags_s           other_flags = '0;
  cpu_request_s           cpu_request;
  int                     err_count = 0, tests_run = 0;
  always #10 core_clk = ~core_clk;
  interrupt_flag_priority_unit dut (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .periph_events, .other_flags, .source_enable, .cpu_request,
    .cpu_vector_ack(ack), .cpu_return(ret), .event_irq);
  cpu_core_model cpu (.core_clk, .reset_n, .accept, .ret_cmd, .cpu_request, .cpu_vector_ack(ack),
    .cpu_return(ret));
  // ***************************************************
  // shared tasks
  // ***************************************************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic stall;
    err_count++;
    report_and_stop;
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic e);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) stall;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic e;
    apb(1'b1, idx, {24'h0, d}, e);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] x);
    logic e;
    apb(1'b0, idx, 32'h0, e);
    `CHK("read data", {24'h0, x}, q)
  endtask
  task automatic pulse(input periph_events_s v);
    @(posedge core_clk);
    periph_events <= v;
    @(posedge core_clk);
    periph_events <= '0;
  endtask
  task automatic wait_req(input logic [4:0] n, input logic [1:0] l);
    int k;
    k = 0;
    repeat (2) @(posedge core_clk);
    while (cpu_request.valid !== 1'b1 && k < 30) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 30) stall;
    `CHK("req number", n, cpu_request.number)
    `CHK("req level", l, cpu_request.level)
  endtask
  task automatic take(input logic [4:0] n, input logic [1:0] l);
    int k;
    k = 0;
    wait_req(n, l);
    accept <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (ack !== 1'b1 && k < 30);
    if (k >= 30) stall;
    accept <= 1'b0;
  endtask
  task automatic give_back;
    @(posedge core_clk);
    ret_cmd <= 1'b1;
    @(posedge core_clk);
    ret_cmd <= 1'b0;
  endtask
  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_reset;
    logic [7:0] ix [5] = '{IDX_RADIO_FLAGS, IDX_TIMER_DMA_FLAGS, IDX_PORT_SER_FLAGS, IDX_PRIO_HIGH, IDX_PRIO_LOW};
    logic e;
    foreach (ix[i]) rd(ix[i], 8'h00);
    apb(1'b0, 8'h00, 32'h0, e);
    `CHK("unmapped error", 1'b1, e)
    $display("test reset done");
  endtask
  task automatic t_flags;
    logic [12:0] ev [3] = '{13'h1000, 13'h0FE0, 13'h001F};
    logic [7:0]  ix [3] = '{IDX_RADIO_FLAGS, IDX_TIMER_DMA_FLAGS, IDX_PORT_SER_FLAGS};
    logic [7:0]  ex [3] = '{8'h03, 8'hBF, 8'h1F};
    foreach (ev[i]) begin
      pulse(ev[i]);
      rd(ix[i], ex[i]);
      wr(ix[i], 8'h00);
      rd(ix[i], 8'h00);
      wr(ix[i], 8'hFF);
      rd(ix[i], ex[i]);
      wr(ix[i], 8'h00);
    end
    $display("test flags done");
  endtask
  task automatic t_prio;
    wr(IDX_PRIO_HIGH, 8'hFF);
    rd(IDX_PRIO_HIGH, 8'h3F);
    wr(IDX_PRIO_LOW, 8'hFF);
    rd(IDX_PRIO_LOW, 8'h3F);
    wr(IDX_PRIO_HIGH, 8'h00);
    wr(IDX_PRIO_LOW, 8'h00);
    source_enable <= 18'h11200;
    wr(IDX_RADIO_FLAGS, 8'h01);
    wait_req(5'h10, 2'h0);
    wr(IDX_RADIO_FLAGS, 8'h00);
    pulse(13'h0900);
    wait_req(5'h09, 2'h0);
    wr(IDX_PRIO_HIGH, 8'h10);
    wait_req(5'h0C, 2'h2);
    wr(IDX_PRIO_LOW, 8'h10);
    wait_req(5'h0C, 2'h3);
    $display("test priority done");
  endtask
  task automatic t_preempt;
    take(5'h0C, 2'h3);
    repeat (4) @(posedge core_clk);
    `CHK("lower level held", 1'b0, cpu_request.valid)
    rd(IDX_TIMER_DMA_FLAGS, 8'h02);
    pulse(13'h0800);
    repeat (4) @(posedge core_clk);
    `CHK("same level held", 1'b0, cpu_request.valid)
    give_back;
    take(5'h0C, 2'h3);
    give_back;
    take(5'h09, 2'h0);
    rd(IDX_TIMER_DMA_FLAGS, 8'h00);
    pulse(13'h0800);
    take(5'h0C, 2'h3);
    rd(IDX_IN_SERVICE, 8'h09);
    repeat (3) give_back;
    $display("test preempt done");
  endtask
  task automatic t_irq;
    rd(IDX_EVENT_STATUS, 8'h07);
    wr(IDX_EVENT_MASK, 8'h01);
    @(posedge core_clk);
    `CHK("irq raised", 1'b1, event_irq)
    wr(IDX_EVENT_MASK, 8'h00);
    @(posedge core_clk);
    `CHK("irq masked", 1'b0, event_irq)
    wr(IDX_EVENT_MASK, 8'h01);
    wr(IDX_EVENT_STATUS, 8'h01);
    @(posedge core_clk);
    `CHK("irq cleared", 1'b0, event_irq)
    rd(IDX_EVENT_STATUS, 8'h06);
    $display("test irq done");
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset;
    t_flags;
    t_prio;
    t_preempt;
    t_irq;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    stall;
  end
endmodule // interrupt_flag_priority_unit_tb_top
